/* File: logic/fbpd_defs.vh */
// Constants for the flash block protection decoder
`ifndef FBPD_DEFS_VH
`define FBPD_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define FBPD_OFS_STAT1      12'h000
`define FBPD_OFS_STAT2      12'h004
`define FBPD_OFS_STAT3      12'h008
`define FBPD_OFS_LOCK       12'h00c
`define FBPD_OFS_RESULT     12'h010

// ****************************************
// Field positions
// ****************************************
`define FBPD_GRANULE_BIT    6
`define FBPD_TOPBOT_BIT     5
`define FBPD_EXTENT_HI      4
`define FBPD_EXTENT_LO      2
`define FBPD_COMPL_BIT      6
`define FBPD_SCHEME_BIT     2
`define FBPD_LOCKALL_BIT    0
`define FBPD_RES_DENY_BIT   0
`define FBPD_RES_GRANT_BIT  1
`define FBPD_RES_CNT_HI     15
`define FBPD_RES_CNT_LO     8

// ****************************************
// Reset values
// ****************************************
`define FBPD_RST_STAT1      8'h00
`define FBPD_RST_COMPL      1'b0
`define FBPD_RST_SCHEME     1'b0
`define FBPD_RST_LOCKALL    1'b1

// ****************************************
// Array geometry
// ****************************************
`define FBPD_ARRAY_MAX      20'hfffff
`define FBPD_UNIT_4K        20'h01000
`define FBPD_UNIT_64K       20'h10000
`define FBPD_WIDE32_TOP_HI  20'hf7fff
`define FBPD_WIDE32_BOT_LO  20'h08000
`define FBPD_WIDE64_TOP_HI  20'heffff
`define FBPD_WIDE64_BOT_LO  20'h10000

// ****************************************
// Request operations and erase kinds
// ****************************************
`define FBPD_OP_PROGRAM     3'h0
`define FBPD_OP_ERASE_PAGE  3'h1
`define FBPD_OP_ERASE_4K    3'h2
`define FBPD_OP_ERASE_32K   3'h3
`define FBPD_OP_ERASE_64K   3'h4
`define FBPD_OP_ERASE_CHIP  3'h5
`define FBPD_EK_NONE        2'h0
`define FBPD_EK_32K         2'h1
`define FBPD_EK_64K         2'h2

// ****************************************
// AXI responses
// ****************************************
`define FBPD_RESP_OKAY      2'h0
`define FBPD_RESP_SLVERR    2'h2

`endif

/* File: logic/fbpd_range.v */
// Decoder from protection fields to one protected address range
`timescale 1ns/1ns
`include "fbpd_defs.vh"

module fbpd_range
(
  // Protection fields
  input  wire        compl_bit,
  input  wire        granule_4k,
  input  wire        bottom_sel,
  input  wire [2:0]  extent_code,
  // Erase size that widens the complement region
  input  wire [1:0]  erase_kind,
  // Decoded range, inclusive
  output reg         range_none,
  output reg  [19:0] range_lo,
  output reg  [19:0] range_hi
);

  reg  [1:0]  shift_n;
  reg  [19:0] size_b;
  wire        full_code;

  // Codes past the last step cover the whole array, or nothing when the complement bit is set
  assign full_code = granule_4k ? (extent_code >= 3'h6) : (extent_code >= 3'h5);

  // Region size: granule doubled per step, 4 kB mode saturating at 32 kB
  always @*
  begin
    case (extent_code)
      3'h1:    shift_n = 2'h0;
      3'h2:    shift_n = 2'h1;
      3'h3:    shift_n = 2'h2;
      default: shift_n = 2'h3;
    endcase
    size_b = (granule_4k ? `FBPD_UNIT_4K : `FBPD_UNIT_64K) << shift_n; // RQ4 RQ9
  end

  // Range selection
  always @*
  begin
    range_none = 1'b0;
    range_lo   = 20'h00000;
    range_hi   = `FBPD_ARRAY_MAX;
    if (extent_code == 3'h0)
      range_none = ~compl_bit; // RQ10 RQ11 RQ12
    else if (full_code)
      range_none = compl_bit; // RQ7 RQ8 RQ9 RQ11 RQ12
    else if (!compl_bit)
    begin
      if (bottom_sel)
        range_hi = size_b - 20'h00001; // RQ5 RQ8
      else
        range_lo = 20'h00000 - size_b; // RQ5 RQ7
    end
    else
    begin
      // Complement keeps everything but the small end region
      if (bottom_sel)
        range_lo = size_b; // RQ3 RQ11 RQ12
      else
        range_hi = `FBPD_ARRAY_MAX - size_b; // RQ3 RQ11 RQ12
      if (granule_4k && erase_kind == `FBPD_EK_32K)
      begin
        if (bottom_sel)
          range_lo = `FBPD_WIDE32_BOT_LO; // RQ13
        else
          range_hi = `FBPD_WIDE32_TOP_HI; // RQ13
      end
      if (granule_4k && erase_kind == `FBPD_EK_64K)
      begin
        if (bottom_sel)
          range_lo = `FBPD_WIDE64_BOT_LO; // RQ14
        else
          range_hi = `FBPD_WIDE64_TOP_HI; // RQ14
      end
    end
  end

endmodule

/* File: logic/fbpd_top.v */
// Flash block protection decoder with AXI4-Lite register access
// What this block does
// (RQ1) Scheme bit clear: range fields decide protection
// (RQ2) Scheme bit set: per-block lock state decides; here the single global lock bit decides for every block
// (RQ3) Complement bit inverts the decoded region
// (RQ4) Granule bit picks 4 kB or 64 kB
// (RQ5) Top/bottom bit picks the growing end
// (RQ6) Extent code sizes region; inside it rejected
// (RQ7) 64 kB top: codes step, high codes all
// (RQ8) 64 kB bottom: codes step, high codes all
// (RQ9) 4 kB: 4-32 kB steps, 101 repeats 100
// (RQ10) Code 000 leaves array unprotected
// (RQ11) Complement 64 kB: inverted table of ranges
// (RQ12) Complement 4 kB: inverted table of ranges
// (RQ13) Complement 4 kB: 32 kB erase widened
// (RQ14) Complement 4 kB: 64 kB erase widened
// (RQ15) Page erase works on aligned 256-byte pages
// (RQ16) Page program stays inside one page
// (RQ17) 4 kB granularity; lock all at once
// (RQ18) Overlapping protected request ignored, back idle
// (RQ19) Compare only the low 20 address bits
`timescale 1ns/1ns
`include "fbpd_defs.vh"

module fbpd_top
(
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Request from the command decoder
  input  wire        req_valid,
  input  wire [2:0]  req_op,
  input  wire [23:0] req_addr,
  input  wire [8:0]  req_len,
  output reg         req_busy,
  // Verdict towards the array sequencer
  output reg         op_grant,
  output reg         op_deny,
  output reg  [19:0] op_lo,
  output reg  [19:0] op_hi
);

  // ****************************************
  // Reset release
  // ****************************************

  reg rst_meta_q;
  reg rst_n_q;

  // Async assert, release through two flops
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  reg  [7:0]  stat1_q;
  reg         compl_q;
  reg         scheme_q;
  reg         lockall_q;
  reg         last_deny_q;
  reg         last_grant_q;
  reg  [7:0]  deny_cnt_q;
  reg  [11:0] awaddr_q;
  reg         aw_full_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_full_q;
  reg  [31:0] rd_d;
  reg  [1:0]  rresp_d;
  wire        wr_go;
  wire        wr_hit;

  assign wr_go  = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_hit = (awaddr_q[11:2] == `FBPD_OFS_STAT1 >> 2) ||
                  (awaddr_q[11:2] == `FBPD_OFS_STAT2 >> 2) ||
                  (awaddr_q[11:2] == `FBPD_OFS_STAT3 >> 2) ||
                  (awaddr_q[11:2] == `FBPD_OFS_LOCK >> 2);

  // Address and data are taken independently; write happens once both held
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FBPD_RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      stat1_q       <= `FBPD_RST_STAT1;
      compl_q       <= `FBPD_RST_COMPL;
      scheme_q      <= `FBPD_RST_SCHEME;
      lockall_q     <= `FBPD_RST_LOCKALL;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `FBPD_RESP_OKAY : `FBPD_RESP_SLVERR;
        // All writable fields sit in byte lane 0
        if (wstrb_q[0])
        begin
          case (awaddr_q[11:2])
            `FBPD_OFS_STAT1 >> 2:
              stat1_q <= wdata_q[7:0] & 8'h7c;
            `FBPD_OFS_STAT2 >> 2:
              compl_q <= wdata_q[`FBPD_COMPL_BIT];
            `FBPD_OFS_STAT3 >> 2:
              scheme_q <= wdata_q[`FBPD_SCHEME_BIT];
            `FBPD_OFS_LOCK >> 2:
              lockall_q <= wdata_q[`FBPD_LOCKALL_BIT]; // RQ17
            default:
              stat1_q <= stat1_q;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read mux; unmapped words read zero with an error answer
  always @*
  begin
    rd_d    = 32'h0000_0000;
    rresp_d = `FBPD_RESP_OKAY;
    case (s_axi_araddr[11:2])
      `FBPD_OFS_STAT1 >> 2:
        rd_d[7:0] = stat1_q;
      `FBPD_OFS_STAT2 >> 2:
        rd_d[`FBPD_COMPL_BIT] = compl_q;
      `FBPD_OFS_STAT3 >> 2:
        rd_d[`FBPD_SCHEME_BIT] = scheme_q;
      `FBPD_OFS_LOCK >> 2:
        rd_d[`FBPD_LOCKALL_BIT] = lockall_q;
      `FBPD_OFS_RESULT >> 2:
      begin
        rd_d[`FBPD_RES_DENY_BIT]                    = last_deny_q;
        rd_d[`FBPD_RES_GRANT_BIT]                   = last_grant_q;
        rd_d[`FBPD_RES_CNT_HI:`FBPD_RES_CNT_LO]     = deny_cnt_q;
      end
      default:
        rresp_d = `FBPD_RESP_SLVERR;
    endcase
  end

  // Read channel: one read in flight
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FBPD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_d;
      s_axi_rresp   <= rresp_d;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Request capture and target range
  // ****************************************

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_CHECK = 3'b010;
  localparam [2:0] ST_RESP  = 3'b100;

  reg  [2:0]  state_q;
  reg  [19:0] tgt_lo_q;
  reg  [19:0] tgt_hi_q;
  reg  [1:0]  ekind_q;
  reg         bad_q;
  reg  [19:0] tgt_lo_d;
  reg  [19:0] tgt_hi_d;
  reg  [1:0]  ekind_d;
  reg         bad_d;
  reg  [8:0]  pg_end;
  wire [19:0] a20;

  assign a20 = req_addr[19:0]; // RQ19

  // Target range per operation, aligned to its erase unit
  always @*
  begin
    tgt_lo_d = a20;
    tgt_hi_d = a20;
    ekind_d  = `FBPD_EK_NONE;
    bad_d    = 1'b0;
    pg_end   = {1'b0, a20[7:0]} + req_len - 9'h001;
    case (req_op)
      `FBPD_OP_PROGRAM:
      begin
        bad_d = (req_len == 9'h000) || (req_len > 9'h100); // RQ16
        // A run past the page end wraps, so the whole page is at stake
        if (pg_end[8])
        begin
          tgt_lo_d = {a20[19:8], 8'h00}; // RQ16
          tgt_hi_d = {a20[19:8], 8'hff};
        end
        else
          tgt_hi_d = {a20[19:8], pg_end[7:0]}; // RQ16
      end
      `FBPD_OP_ERASE_PAGE:
      begin
        tgt_lo_d = {a20[19:8], 8'h00}; // RQ15
        tgt_hi_d = {a20[19:8], 8'hff}; // RQ15
      end
      `FBPD_OP_ERASE_4K:
      begin
        tgt_lo_d = {a20[19:12], 12'h000}; // RQ17
        tgt_hi_d = {a20[19:12], 12'hfff};
      end
      `FBPD_OP_ERASE_32K:
      begin
        tgt_lo_d = {a20[19:15], 15'h0000};
        tgt_hi_d = {a20[19:15], 15'h7fff};
        ekind_d  = `FBPD_EK_32K; // RQ13
      end
      `FBPD_OP_ERASE_64K:
      begin
        tgt_lo_d = {a20[19:16], 16'h0000};
        tgt_hi_d = {a20[19:16], 16'hffff};
        ekind_d  = `FBPD_EK_64K; // RQ14
      end
      `FBPD_OP_ERASE_CHIP:
      begin
        tgt_lo_d = 20'h00000;
        tgt_hi_d = `FBPD_ARRAY_MAX;
      end
      default:
        bad_d = 1'b1;
    endcase
  end

  // ****************************************
  // Protected range and verdict
  // ****************************************

  wire        prot_none;
  wire [19:0] prot_lo;
  wire [19:0] prot_hi;
  wire        overlap;
  wire        protect_hit;

  // Fields read from the live registers at check time
  fbpd_range u_range
  (
    .compl_bit   (compl_q),
    .granule_4k  (stat1_q[`FBPD_GRANULE_BIT]),
    .bottom_sel  (stat1_q[`FBPD_TOPBOT_BIT]),
    .extent_code (stat1_q[`FBPD_EXTENT_HI:`FBPD_EXTENT_LO]),
    .erase_kind  (ekind_q),
    .range_none  (prot_none),
    .range_lo    (prot_lo),
    .range_hi    (prot_hi)
  );

  assign overlap     = !prot_none && (tgt_lo_q <= prot_hi) && (tgt_hi_q >= prot_lo); // RQ6
  // Lock scheme has no per-block bits here: the global lock covers all
  assign protect_hit = scheme_q ? lockall_q : overlap; // RQ1 RQ2 RQ17

  // Idle -> check -> answer -> idle; one request at a time
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q      <= ST_IDLE;
      tgt_lo_q     <= 20'h00000;
      tgt_hi_q     <= 20'h00000;
      ekind_q      <= `FBPD_EK_NONE;
      bad_q        <= 1'b0;
      req_busy     <= 1'b0;
      op_grant     <= 1'b0;
      op_deny      <= 1'b0;
      op_lo        <= 20'h00000;
      op_hi        <= 20'h00000;
      last_deny_q  <= 1'b0;
      last_grant_q <= 1'b0;
      deny_cnt_q   <= 8'h00;
    end
    else
    begin
      op_grant <= 1'b0;
      op_deny  <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            tgt_lo_q <= tgt_lo_d;
            tgt_hi_q <= tgt_hi_d;
            ekind_q  <= ekind_d;
            bad_q    <= bad_d;
            req_busy <= 1'b1;
            state_q  <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          op_lo        <= tgt_lo_q;
          op_hi        <= tgt_hi_q;
          op_grant     <= !(protect_hit || bad_q); // RQ10
          op_deny      <= protect_hit || bad_q; // RQ18
          last_grant_q <= !(protect_hit || bad_q);
          last_deny_q  <= protect_hit || bad_q;
          if ((protect_hit || bad_q) && deny_cnt_q != 8'hff)
            deny_cnt_q <= deny_cnt_q + 8'h01;
          state_q <= ST_RESP;
        end
        ST_RESP:
        begin
          req_busy <= 1'b0;
          state_q  <= ST_IDLE; // RQ18
        end
        default:
        begin
          req_busy <= 1'b0;
          state_q  <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: testbench/fbpd_props.sv */
// Port assertions for the protection decoder
`timescale 1ns/1ns
module fbpd_props
(
  // Clock and reset
  input wire        clk,
  input wire        arst_n,
  // Bus answers
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Requests and verdicts
  input wire [2:0]  req_op,
  input wire [8:0]  req_len,
  input wire        req_busy,
  input wire        op_grant,
  input wire        op_deny
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_excl;
    !(op_grant && op_deny);
  endproperty
  a_excl: assert property (p_excl) else $error("grant with deny");

  // Busy start means a verdict is close behind
  property p_verdict;
    $rose(req_busy) |-> ##[1:3] (op_grant || op_deny);
  endproperty
  a_verdict: assert property (p_verdict) else $error("no verdict");

  property p_idle;
    $rose(req_busy) |-> ##[1:4] !req_busy;
  endproperty
  a_idle: assert property (p_idle) else $error("stuck busy");

  property p_pulse;
    (op_grant || op_deny) |=> !(op_grant || op_deny);
  endproperty
  a_pulse: assert property (p_pulse) else $error("verdict too long");

  // Empty or oversize program never reaches the array
  property p_badlen;
    $rose(req_busy) && $past(req_op) == 3'h0 && ($past(req_len) == 9'h000
      || $past(req_len) > 9'h100) |-> ##[1:3] op_deny;
  endproperty
  a_badlen: assert property (p_badlen) else $error("bad length passed");

  property p_badop;
    $rose(req_busy) && $past(req_op) > 3'h5 |-> ##[1:3] op_deny;
  endproperty
  a_badop: assert property (p_badop) else $error("bad op passed");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");

  property p_rerr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h013 |=> s_axi_rvalid
      && s_axi_rresp == 2'h2;
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
endmodule

bind fbpd_top fbpd_props props_u (.clk, .arst_n, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .req_op, .req_len, .req_busy, .op_grant, .op_deny);

/* File: testbench/fbpd_host_model.sv */
// Command-side host model issuing program and erase requests
`timescale 1ns/1ns
module fbpd_host_model
(
  // Clock and verdicts
  input wire        clk,
  input wire        req_busy,
  input wire        op_grant,
  input wire        op_deny,
  // Request
  output reg        req_valid = 1'h0,
  output reg [2:0]  req_op = 3'h0,
  output reg [23:0] req_addr = 24'h000000,
  output reg [8:0]  req_len = 9'h001
);
  // ****
  // One request, then wait for its verdict
  // ****
  task send(input [2:0] op, input [23:0] a, input [8:0] n, input int gap);
    begin
      repeat (gap) @(posedge clk);
      while (req_busy) @(posedge clk);
      req_valid <= 1'h1;
      req_op <= op;
      req_addr <= a;
      req_len <= n;
      @(posedge clk);
      req_valid <= 1'h0;
      // Scrambled after release so a late sample never matches
      req_addr <= ~a;
      req_len <= ~n;
      do @(posedge clk); while (!(op_grant || op_deny));
      @(posedge clk);
    end
  endtask
endmodule

/* File: testbench/fbpd_top_tb.sv */
// Self-checking bench for the protection decoder
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module fbpd_top_tb;
  logic        clk = 1'h0, arst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, ea;
  logic [3:0]  s_axi_wstrb = 4'hf;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         req_valid, req_busy, op_grant, op_deny;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   req_op;
  wire [23:0]  req_addr;
  wire [8:0]   req_len;
  wire [19:0]  op_lo, op_hi;
  int          failures = 0, n_checks = 0, cyc = 0;
  logic [31:0] aq[$];
  logic [41:0] vq[$], ev;
  logic [7:0]  nd = 8'h00;
  logic        cm, g, bt, sch = 1'h0, lk = 1'h1;
  logic [2:0]  c;
  // Probes: op in the top nibble, boundary address below
  logic [23:0] pt[16] = '{24'h2ff000, 24'h2fe000, 24'h2f8000, 24'h2f7000, 24'h2f0000,
    24'h280000, 24'h27f000, 24'h208000, 24'h200000, 24'h400000, 24'h3f8000,
    24'h3f0000, 24'h308000, 24'h4f0000, 24'h4e0000, 24'h410000};

  always #50 clk = ~clk;

  fbpd_top dut_u (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_op,
    .req_addr, .req_len, .req_busy, .op_grant, .op_deny, .op_lo, .op_hi);
  fbpd_host_model host_u (.clk, .req_busy, .op_grant, .op_deny, .req_valid, .req_op,
    .req_addr, .req_len);

  // ****
  // Reference {target lo, target hi, grant, deny}
  // ****
  function automatic logic [41:0] expv(input [2:0] op, input [19:0] a, input [8:0] n);
    logic [19:0] tl, th, pl, ph, sz;
    logic        pn;
    begin
      pn = 1'h0;
      pl = 20'h00000;
      ph = 20'hfffff;
      sz = g ? 20'h01000 << (c == 3'h5 ? 3 : c - 1) : 20'h10000 << (c - 1);
      if (c == 3'h0 || c > (g ? 3'h5 : 3'h4))
        pn = (c == 3'h0) ^ cm;
      else if (!cm && !bt)
        pl = 20'h00000 - sz;
      else if (!cm)
        ph = sz - 20'h00001;
      else if (!bt)
        ph = (g && op == 3'h3) ? 20'hf7fff : (g && op == 3'h4) ? 20'heffff : ~sz;
      else
        pl = (g && op == 3'h3) ? 20'h08000 : (g && op == 3'h4) ? 20'h10000 : sz;
      th = a + n - 20'h00001;
      tl = a;
      // Wrapping program is judged on its whole page
      if (op == 3'h1 || (op == 3'h0 && th[19:8] != a[19:8]))
        {tl, th} = {a[19:8], 8'h00, a[19:8], 8'hff};
      if (op == 3'h2)
        {tl, th} = {a[19:12], 12'h000, a[19:12], 12'hfff};
      if (op == 3'h3)
        {tl, th} = {a[19:15], 15'h0000, a[19:15], 15'h7fff};
      if (op == 3'h4)
        {tl, th} = {a[19:16], 16'h0000, a[19:16], 16'hffff};
      if (op == 3'h5)
        {tl, th} = {20'h00000, 20'hfffff};
      if (op > 3'h5 || (op == 3'h0 && (n == 9'h000 || n > 9'h100)))
        expv = {tl, th, 2'h1};
      else if (sch)
        expv = {tl, th, lk ? 2'h1 : 2'h2};
      else
        expv = {tl, th, (!pn && tl <= ph && th >= pl) ? 2'h1 : 2'h2};
    end
  endfunction

  // ****
  // Bus and request drivers
  // ****
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      aq.push_back({30'h0, er});
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do
      begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      // Late ready keeps the answer waiting a little
      repeat ($urandom_range(2)) @(posedge clk);
      s_axi_bready <= 1'h1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] e);
    begin
      aq.push_back(e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
    end
  endtask

  task req(input [2:0] op, input [23:0] a, input [8:0] n);
    logic [41:0] v;
    begin
      v = expv(op, a[19:0], n);
      vq.push_back(v);
      // Deny tally saturates like the result counter
      if (v[0] && nd != 8'hff)
        nd++;
      host_u.send(op, a, n, $urandom_range(2));
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Result watcher and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ev = vq.size() ? vq[0] : 'x;
    ea = aq.size() ? aq[0] : 32'hx;
    if (op_grant || op_deny)
    begin
      if (vq.size()) void'(vq.pop_front());
      `CHK({op_lo, op_hi, op_grant, op_deny}, ev)
    end
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      if (aq.size()) void'(aq.pop_front());
      `CHK(s_axi_bvalid ? {30'h0, s_axi_bresp} : s_axi_rdata, ea)
    end
    if (cyc == 30000)
    begin
      failures++;
      final_report;
    end
  end

  initial
  begin
    void'($urandom(32'hda0fa911));
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h1);
    rd(12'h010, 32'h0);
    rd(12'h020, 32'h0);
    wr(12'h010, 32'h3, 2'h2);
    wr(12'h024, 32'h0, 2'h2);
    // Lane 0 disabled: mapped write answers but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(12'h000, 32'h7c, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h000, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 64; k++)
    begin
      {cm, g, bt, c} = k[5:0];
      wr(12'h000, {25'h0, g, bt, c, 2'h0}, 2'h0);
      wr(12'h004, {25'h0, cm, 6'h0}, 2'h0);
      for (int j = 0; j < 16; j++)
        req(pt[j][22:20], {4'($urandom), pt[j][19:0]}, 9'h001);
      for (int j = 0; j < 4; j++)
        req(3'($urandom_range(4)), 24'($urandom), 9'($urandom_range(1, 256)));
    end
    rd(12'h000, 32'h7c);
    req(3'h0, 24'h0fef80, 9'h100);
    $display("test range sweep done");
    sch = 1'h1;
    wr(12'h008, 32'h4, 2'h0);
    req(3'h5, 24'h000000, 9'h001);
    lk = 1'h0;
    wr(12'h00c, 32'h0, 2'h0);
    for (int o = 0; o < 8; o++)
      req(3'(o), 24'($urandom), 9'h001);
    req(3'h0, 24'h000010, 9'h000);
    req(3'h0, 24'h000000, 9'h101);
    rd(12'h010, {16'h0, nd, 8'h01});
    $display("test scheme and requests done");
    final_report;
  end
endmodule
